// [djk_pkg.sv]
// Package for the dual J-K flip-flop block: channel count, synchroniser depth and reset values.
// Assumes a single system clock; every pin input is asynchronous to it.
package djk_pkg;

  // Number of independent flip-flop channels.
  localparam int unsigned NUM_CH = 2;

  // Flip-flops in each pin synchroniser.
  localparam int unsigned SYNC_STAGES = 2;

  // Stored state after system reset (true output low).
  localparam logic RST_STATE = 1'b0;

  // Reset values of synchronised pins: clock low, set and clear inactive high.
  localparam logic RST_PIN_CLK   = 1'b0;
  localparam logic RST_PIN_ASYNC = 1'b1;
  localparam logic RST_PIN_DATA  = 1'b0;

endpackage : djk_pkg

// [djk_sync.sv]
// Multi-stage synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to ref_clk; reset is synchronous and active high.
`timescale 1ns/1ps
`default_nettype none
module djk_sync #(
  parameter int unsigned WIDTH    = 1,
  parameter int unsigned STAGES   = 2,
  parameter logic        RST_VAL  = 1'b0
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pinIn,
  output var  logic [WIDTH-1:0] syncOut
);
  import djk_pkg::*;

  logic [WIDTH-1:0] stage [STAGES-1];

  // First stage is read only by the next stage.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < STAGES - 1; i++) begin
        stage[i] <= {WIDTH{RST_VAL}};
      end
      syncOut <= {WIDTH{RST_VAL}};
    end else begin
      stage[0] <= pinIn;
      for (int i = 1; i < STAGES - 1; i++) begin
        stage[i] <= stage[i-1];
      end
      syncOut <= stage[STAGES-2];
    end
  end

endmodule : djk_sync
`default_nettype wire

// [djk_dual.sv]
// Dual positive-edge J-K flip-flop with active-low set and clear, modelled on ref_clk.
// Assumes all inputs are board pins asynchronous to ref_clk and much slower than it.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Two identical independent channels each have clock, J, inverted K, set, clear and two outputs.
// - Set low with clear high forces true output high and complement low regardless of clock and data.
// - Clear low with set high forces true output low and complement high regardless of clock and data.
// - Set and clear both low drive both outputs high without storing that condition.
// - Leaving the both-low condition, outputs follow the input still low or else the stored state.
// - With set and clear high a rising clock clears, sets, holds or toggles per J and inverted K.
// - With set and clear high, stored state changes only on a rising clock edge and holds at every other time.
module djk_dual #(
  parameter int unsigned CHANNELS = djk_pkg::NUM_CH
) (
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  input  wire logic [CHANNELS-1:0] chanClk,
  input  wire logic [CHANNELS-1:0] jIn,
  input  wire logic [CHANNELS-1:0] kInv_n,
  input  wire logic [CHANNELS-1:0] asyncOne_n,
  input  wire logic [CHANNELS-1:0] asyncZero_n,
  output var  logic [CHANNELS-1:0] stateOut,
  output var  logic [CHANNELS-1:0] stateOutBar
);
  import djk_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [CHANNELS-1:0] clkSync;
  logic [CHANNELS-1:0] jSync;
  logic [CHANNELS-1:0] kSync_n;
  logic [CHANNELS-1:0] oneSync_n;
  logic [CHANNELS-1:0] zeroSync_n;

  djk_sync #(.WIDTH(CHANNELS), .STAGES(SYNC_STAGES), .RST_VAL(RST_PIN_CLK)) uClkSync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .pinIn   (chanClk),
    .syncOut (clkSync)
  );

  // Data passes the same depth as the clock, so setup at the pins carries through.
  djk_sync #(.WIDTH(CHANNELS), .STAGES(SYNC_STAGES), .RST_VAL(RST_PIN_DATA)) uJSync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .pinIn   (jIn),
    .syncOut (jSync)
  );

  djk_sync #(.WIDTH(CHANNELS), .STAGES(SYNC_STAGES), .RST_VAL(RST_PIN_DATA)) uKSync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .pinIn   (kInv_n),
    .syncOut (kSync_n)
  );

  djk_sync #(.WIDTH(CHANNELS), .STAGES(SYNC_STAGES), .RST_VAL(RST_PIN_ASYNC)) uOneSync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .pinIn   (asyncOne_n),
    .syncOut (oneSync_n)
  );

  djk_sync #(.WIDTH(CHANNELS), .STAGES(SYNC_STAGES), .RST_VAL(RST_PIN_ASYNC)) uZeroSync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .pinIn   (asyncZero_n),
    .syncOut (zeroSync_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel flip-flop logic.

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : gChan
      logic clkPrev;
      logic priorState;
      wire  clkRise;
      wire  forceOne;
      wire  forceZero;
      wire  forceBoth;
      wire  jkNext;
      wire  next_state;

      // Decode of the asynchronous inputs and the clock edge.
      assign clkRise   = clkSync[ch] & ~clkPrev;
      assign forceOne  = ~oneSync_n[ch] & zeroSync_n[ch];
      assign forceZero = oneSync_n[ch] & ~zeroSync_n[ch];
      assign forceBoth = ~oneSync_n[ch] & ~zeroSync_n[ch];

      // Clocked J-K table; tied J and inverted K give D-type, J high with inverted K low toggles.
      assign jkNext = jSync[ch] ? (kSync_n[ch] ? 1'b1 : ~priorState)
                                : (kSync_n[ch] ? priorState : 1'b0);

      // Both-low keeps the stored state so release falls back to it.
      assign next_state = forceOne  ? 1'b1 :
                          forceZero ? 1'b0 :
                          forceBoth ? priorState :
                          clkRise   ? jkNext : priorState;

      // Clock history and stored state; reset gives a defined start.
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          clkPrev    <= RST_PIN_CLK;
          priorState <= RST_STATE;
        end else begin
          clkPrev    <= clkSync[ch];
          priorState <= next_state;
        end
      end

      // Outputs registered; both high only while set and clear are both low.
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          stateOut[ch]    <= RST_STATE;
          stateOutBar[ch] <= ~RST_STATE;
        end else begin
          stateOut[ch]    <= forceBoth | next_state;
          stateOutBar[ch] <= forceBoth | ~next_state;
        end
      end
    end
  endgenerate

endmodule : djk_dual
`default_nettype wire

// [djk_board.sv]
// Board logic model: turns a one-cycle fire request into a 4-cycle channel clock pulse.
// Assumes fire requests come at least 8 ref_clk cycles apart.
`timescale 1ns/1ps
`default_nettype none
module djk_board (
  input  wire logic       ref_clk,
  input  wire logic [1:0] fire,
  output var  logic [1:0] chanClk
);
  logic [1:0][3:0] hold = '0;
  // Shift each request along, so the pin is high 4 cycles and low between pulses.
  always @(posedge ref_clk) for (int i = 0; i < 2; i++) hold[i] <= {hold[i][2:0], fire[i]};
  always_comb for (int i = 0; i < 2; i++) chanClk[i] = |hold[i];
endmodule : djk_board
`default_nettype wire

// [djk_dual_chk.sv]
// Checker: ties held pin levels to output levels at the synchronised latency.
// Sees only the ports of djk_dual; pins are held for several clocks at a time.
`timescale 1ns/1ps
`default_nettype none
module djk_dual_chk #(parameter int unsigned CHANNELS = 2) (
  input wire logic                ref_clk,
  input wire logic                sys_rst,
  input wire logic [CHANNELS-1:0] chanClk,
  input wire logic [CHANNELS-1:0] jIn,
  input wire logic [CHANNELS-1:0] kInv_n,
  input wire logic [CHANNELS-1:0] asyncOne_n,
  input wire logic [CHANNELS-1:0] asyncZero_n,
  input wire logic [CHANNELS-1:0] stateOut,
  input wire logic [CHANNELS-1:0] stateOutBar
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Forced levels must show within five clocks of a held set or clear.
  a_set_wins: assert property (
    (!asyncOne_n[0] && asyncZero_n[0])[*5] |-> stateOut[0] && !stateOutBar[0])
    else $error("set level wrong");
  a_clear_wins: assert property (
    (asyncOne_n[0] && !asyncZero_n[0])[*5] |-> !stateOut[0] && stateOutBar[0])
    else $error("clear level wrong");
  a_both_high: assert property (
    (!asyncOne_n[0] && !asyncZero_n[0])[*5] |-> stateOut[0] && stateOutBar[0])
    else $error("both-low level wrong");
  a_leave_both: assert property (
    (!asyncOne_n[0] && !asyncZero_n[0])[*5] ##1 (!asyncOne_n[0] && asyncZero_n[0])[*5]
    |-> stateOut[0] && !stateOutBar[0]) else $error("both-low persisted");
  a_ch1_clear: assert property (
    (asyncOne_n[1] && !asyncZero_n[1])[*5] |-> !stateOut[1] && stateOutBar[1])
    else $error("second channel clear wrong");
  // A clock rise loads the next state four clocks later.
  a_clock_load: assert property (
    $rose(chanClk[0]) && asyncOne_n[0] && asyncZero_n[0] |=> ##3 stateOut[0] == (
    $past(kInv_n[0], 4) ? $past(jIn[0] | stateOut[0], 4) : $past(jIn[0] & ~stateOut[0], 4)))
    else $error("clocked load wrong");
  a_state_hold: assert property (
    (asyncOne_n[0] && asyncZero_n[0] && !$rose(chanClk[0]))[*6] |-> $stable(stateOut[0]))
    else $error("state moved without clock");
  a_reset_state: assert property (disable iff (1'b0)
    $fell(sys_rst) |-> stateOut == 2'h0 && stateOutBar == 2'h3) else $error("reset state");
endmodule : djk_dual_chk
bind djk_dual djk_dual_chk #(.CHANNELS(CHANNELS)) u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .chanClk(chanClk), .jIn(jIn), .kInv_n(kInv_n), .asyncOne_n(asyncOne_n),
  .asyncZero_n(asyncZero_n), .stateOut(stateOut), .stateOutBar(stateOutBar));
`default_nettype wire

// [dual_jk_flip_flop_tb_top.sv]
// Bench: a table of clocked loads, then set, clear and hold cases written out.
// Assumes djk_board makes the channel clock pulses.
`timescale 1ns/1ps
`default_nettype none
module dual_jk_flip_flop_tb_top;
  import djk_pkg::*;
  logic       ref_clk = 1'b0, sys_rst = 1'b1;
  logic [1:0] fire = 2'h0, jIn = 2'h0, kInv_n = 2'h0, asyncOne_n = 2'h3, asyncZero_n = 2'h3;
  logic [1:0] chanClk, stateOut, stateOutBar;
  int         error_cnt = 0, compares = 0, cycles = 0;
  logic [2:0] rows [6] = '{3'h7, 3'h3, 3'h4, 3'h5, 3'h0, 3'h2};
  djk_board BRD (.ref_clk(ref_clk), .fire(fire), .chanClk(chanClk));
  djk_dual DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .chanClk(chanClk), .jIn(jIn),
    .kInv_n(kInv_n), .asyncOne_n(asyncOne_n), .asyncZero_n(asyncZero_n),
    .stateOut(stateOut), .stateOutBar(stateOutBar));
  // Clock and a cycle ceiling that cuts a hang short.
  initial forever #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (++cycles == 1000) begin
    error_cnt++;
    report_and_stop();
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task automatic chk(input logic [1:0] q, input logic [1:0] qb);
    compares++;
    if (stateOut !== q || stateOutBar !== qb) begin
      error_cnt++;
      $display("unexpected at %0t: outputs %b %b", $time, stateOut, stateOutBar);
    end
    $display("test %0d done", compares);
  endtask : chk
  task automatic pulse;
    tick(3);
    fire <= 2'h3;
    tick(1);
    fire <= 2'h0;
    tick(10);
  endtask : pulse
  task automatic pins(input logic [1:0] one, input logic [1:0] zero);
    asyncOne_n <= one;
    asyncZero_n <= zero;
    tick(6);
  endtask : pins
  task report_and_stop;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // Channel 0 runs the J-K table; channel 1 is wired as a D flip-flop.
  initial begin
    tick(16);
    sys_rst <= 1'b0;
    tick(2);
    chk(2'h0, 2'h3);
    foreach (rows[i]) begin
      jIn <= {2{rows[i][2]}};
      kInv_n <= {rows[i][2], rows[i][1]};
      pulse;
      chk({rows[i][2], rows[i][0]}, ~{rows[i][2], rows[i][0]});
    end
    jIn <= 2'h3;
    kInv_n <= 2'h3;
    tick(8);
    chk(2'h0, 2'h3);
    pins(2'h2, 2'h3);
    chk(2'h1, 2'h2);
    pins(2'h2, 2'h0);
    chk(2'h1, 2'h3);
    pins(2'h2, 2'h3);
    chk(2'h1, 2'h2);
    pins(2'h3, 2'h3);
    chk(2'h1, 2'h2);
    pins(2'h3, 2'h0);
    chk(2'h0, 2'h3);
    pins(2'h0, 2'h0);
    chk(2'h3, 2'h3);
    pins(2'h3, 2'h3);
    chk(2'h0, 2'h3);
    pins(2'h3, 2'h3);
    kInv_n <= 2'h0;
    pulse;
    chk(2'h3, 2'h0);
    pulse;
    chk(2'h0, 2'h3);
    pulse;
    chk(2'h3, 2'h0);
    // A reset in mid-run must drop a stored one back to the defined start.
    sys_rst <= 1'b1;
    tick(4);
    sys_rst <= 1'b0;
    tick(2);
    chk(2'h0, 2'h3);
    report_and_stop();
  end
endmodule : dual_jk_flip_flop_tb_top
`default_nettype wire
